// ---- hw/pmic_seq_params.svh ----
`ifndef PMIC_SEQ_PARAMS_SVH
`define PMIC_SEQ_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_IRQ_STATUS_SECOND      8'h2b
`define OFS_ONOFF_SEQUENCE_FIRST   8'h2c
`define OFS_ONOFF_SEQUENCE_SECOND  8'h2d

// ---------------------------------------------------------------
// Status field positions and reset values
// ---------------------------------------------------------------
`define BIT_KEY_HOLD_SHUTDOWN      7
`define BIT_BUTTON_RISE            6
`define BIT_BUTTON_FALL            5
`define BIT_HIGH_TEMP_PREWARN      1
`define BIT_LOW_TEMP_PREWARN       0
`define RST_IRQ_STATUS_SECOND      8'h00
`define STATUS_LIVE_MASK           8'he3

// ---------------------------------------------------------------
// Slot fields and codes
// ---------------------------------------------------------------
`define SLOT_HI_MSB                7
`define SLOT_HI_LSB                4
`define SLOT_LO_MSB                3
`define SLOT_LO_LSB                0
`define SLOT_OFF                   4'h0
`define SLOT_FIRST_ON              4'h1
`define SLOT_LAST_ON               4'hc
`define RST_SEQ_HOLD               8'h00

// ---------------------------------------------------------------
// Timing and default target address
// ---------------------------------------------------------------
`define CLK_PERIOD_NS              50
`define SEQ_STEP_TIME_NS           1000
`define SEQ_STEP_CYCLES            ((`SEQ_STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TARGET_ADDR_DEFAULT        7'h34

`endif

// ---- hw/pmic_seq_pkg.sv ----
package pmic_seq_pkg;

  typedef logic [3:0] slot_t;

  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_RISE,
    SEQ_ON,
    SEQ_FALL
  } seq_state_e;

  typedef enum logic [3:0] {
    TGT_IDLE,
    TGT_ADDR,
    TGT_ADDR_ACK,
    TGT_PTR,
    TGT_PTR_ACK,
    TGT_WDATA,
    TGT_WDATA_ACK,
    TGT_RDATA,
    TGT_RDATA_ACK
  } tgt_state_e;

endpackage : pmic_seq_pkg

// ---- hw/reg_access_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface reg_access_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;

  modport target (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata
  );

  modport regfile (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata
  );
endinterface : reg_access_if

`default_nettype wire

// ---- hw/two_wire_target.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pmic_seq_params.svh"

module two_wire_target #(
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT
) (
  input  wire logic     i_clk_sys,
  input  wire logic     i_rst_b,
  input  wire logic     i_scl,
  input  wire logic     i_sda,
  output logic          o_sda_o,
  output logic          o_sda_oe,
  reg_access_if.target  bus
);
  import pmic_seq_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_s      = scl_sync_reg[1];
  assign sda_s      = sda_sync_reg[1];
  assign scl_rise   = scl_s & ~scl_prev_reg;
  assign scl_fall   = ~scl_s & scl_prev_reg;
  assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_seen  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  tgt_state_e state_reg;
  logic [2:0] bit_cnt_reg;
  logic       byte_full_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic       pull_low_reg;
  logic       nack_reg;
  logic       wr_reg;
  logic       rd_reg;
  logic       is_receive;

  assign is_receive = (state_reg == TGT_ADDR) || (state_reg == TGT_PTR) || (state_reg == TGT_WDATA);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_reg     <= TGT_IDLE;
      bit_cnt_reg   <= 3'h0;
      byte_full_reg <= 1'b0;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      pull_low_reg  <= 1'b0;
      nack_reg      <= 1'b0;
      wr_reg        <= 1'b0;
      rd_reg        <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (start_seen) begin
        state_reg     <= TGT_ADDR;
        bit_cnt_reg   <= 3'h0;
        byte_full_reg <= 1'b0;
        pull_low_reg  <= 1'b0;
      end else if (stop_seen) begin
        state_reg    <= TGT_IDLE;
        pull_low_reg <= 1'b0;
      end else if (is_receive && scl_rise) begin
        shift_reg     <= {shift_reg[6:0], sda_s};
        bit_cnt_reg   <= bit_cnt_reg + 3'h1;
        byte_full_reg <= (bit_cnt_reg == 3'h7);
      end else if (is_receive && scl_fall && byte_full_reg) begin
        byte_full_reg <= 1'b0;
        case (state_reg)
          TGT_ADDR: begin
            if (shift_reg[7:1] == TARGET_ADDR) begin
              nack_reg     <= shift_reg[0];
              pull_low_reg <= 1'b1;
              state_reg    <= TGT_ADDR_ACK;
            end else begin
              state_reg <= TGT_IDLE;
            end
          end
          TGT_PTR: begin
            ptr_reg      <= shift_reg;
            pull_low_reg <= 1'b1;
            state_reg    <= TGT_PTR_ACK;
          end
          default: begin
            wr_reg       <= 1'b1;
            pull_low_reg <= 1'b1;
            state_reg    <= TGT_WDATA_ACK;
          end
        endcase
      end else if (scl_rise && state_reg == TGT_RDATA_ACK) begin
        nack_reg <= sda_s;
      end else if (scl_fall) begin
        case (state_reg)
          TGT_ADDR_ACK, TGT_RDATA_ACK: begin
            // Read flag sits in nack_reg after an address byte
            if (state_reg == TGT_ADDR_ACK && !nack_reg) begin
              pull_low_reg <= 1'b0;
              bit_cnt_reg  <= 3'h0;
              state_reg    <= TGT_PTR;
            end else if (state_reg == TGT_RDATA_ACK && nack_reg) begin
              pull_low_reg <= 1'b0;
              state_reg    <= TGT_IDLE;
            end else begin
              // Fetch counts as the read, so clear-on-read fires once per byte
              shift_reg    <= bus.rdata;
              rd_reg       <= 1'b1;
              pull_low_reg <= ~bus.rdata[7];
              bit_cnt_reg  <= 3'h0;
              state_reg    <= TGT_RDATA;
            end
          end
          TGT_PTR_ACK: begin
            pull_low_reg <= 1'b0;
            bit_cnt_reg  <= 3'h0;
            state_reg    <= TGT_WDATA;
          end
          TGT_WDATA_ACK: begin
            pull_low_reg <= 1'b0;
            bit_cnt_reg  <= 3'h0;
            ptr_reg      <= ptr_reg + 8'h01;
            state_reg    <= TGT_WDATA;
          end
          TGT_RDATA: begin
            if (bit_cnt_reg == 3'h7) begin
              pull_low_reg <= 1'b0;
              ptr_reg      <= ptr_reg + 8'h01;
              state_reg    <= TGT_RDATA_ACK;
            end else begin
              shift_reg    <= {shift_reg[6:0], 1'b0};
              pull_low_reg <= ~shift_reg[6];
              bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            end
          end
          default: begin
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end

  assign bus.addr  = ptr_reg;
  assign bus.wdata = shift_reg;
  assign bus.wr    = wr_reg;
  assign bus.rd    = rd_reg;
  assign o_sda_o   = 1'b0;
  assign o_sda_oe  = pull_low_reg;

endmodule : two_wire_target

`default_nettype wire

// ---- hw/pmic_status_and_sequence_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pmic_seq_params.svh"

module pmic_status_and_sequence_regs #(
  parameter logic [6:0] TARGET_ADDR     = `TARGET_ADDR_DEFAULT,
  parameter int         RAILS           = 4,
  parameter int         SEQ_STEP_CYCLES = `SEQ_STEP_CYCLES
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  input  wire logic       i_power_button_input,
  input  wire logic       i_key_hold_shutdown,
  input  wire logic       i_high_temp_prewarn,
  input  wire logic       i_low_temp_prewarn,
  input  wire logic [7:0] i_option_seq_first,
  input  wire logic [7:0] i_option_seq_second,
  input  wire logic       i_seq_on_req,
  output logic [3:0]      o_rail_en,
  output logic            o_seq_busy,
  output logic            o_seq_up
);
  import pmic_seq_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (RAILS != 4) begin : g_bad_rails
    $error("RAILS must be 4: two sequence registers hold four slots");
  end
  if (SEQ_STEP_CYCLES < 1 || SEQ_STEP_CYCLES > 65535) begin : g_bad_step
    $error("SEQ_STEP_CYCLES out of range 1..65535");
  end
  if ((`SLOT_HI_MSB - `SLOT_HI_LSB + 1) != $bits(slot_t)) begin : g_bad_hi_field
    $error("Upper slot field must be four bits wide");
  end
  if ((`SLOT_LO_MSB - `SLOT_LO_LSB + 1) != $bits(slot_t)) begin : g_bad_lo_field
    $error("Lower slot field must be four bits wide");
  end
  if ((`STATUS_LIVE_MASK & 8'h1c) != 8'h00) begin : g_bad_mask
    $error("Reserved status bits must stay masked");
  end

  localparam logic [15:0] STEP_RELOAD = 16'(SEQ_STEP_CYCLES - 1);

  // ---------------------------------------------------------------
  // Register access from the two-wire port
  // ---------------------------------------------------------------
  reg_access_if bus ();

  two_wire_target #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_target (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda_o   (o_sda_o),
    .o_sda_oe  (o_sda_oe),
    .bus       (bus.target)
  );

  logic wr_seq_first;
  logic wr_seq_second;
  logic rd_status;

  assign wr_seq_first  = bus.wr && (bus.addr == `OFS_ONOFF_SEQUENCE_FIRST);
  assign wr_seq_second = bus.wr && (bus.addr == `OFS_ONOFF_SEQUENCE_SECOND);
  assign rd_status     = bus.rd && (bus.addr == `OFS_IRQ_STATUS_SECOND);

  // ---------------------------------------------------------------
  // Power button synchroniser and edge detect
  // ---------------------------------------------------------------
  logic [1:0] button_sync_reg;
  logic       button_prev_reg;
  logic       button_rise;
  logic       button_fall;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      button_sync_reg <= 2'h0;
      button_prev_reg <= 1'b0;
    end else begin
      button_sync_reg <= {button_sync_reg[0], i_power_button_input};
      button_prev_reg <= button_sync_reg[1];
    end
  end

  // Reset state of the button is taken as low, so a held button reports a rise
  assign button_rise = button_sync_reg[1] & ~button_prev_reg;
  assign button_fall = ~button_sync_reg[1] & button_prev_reg;

  // ---------------------------------------------------------------
  // Interrupt status, sticky, cleared on read
  // ---------------------------------------------------------------
  logic [7:0] irq_status_second_reg;
  logic [7:0] irq_status_second_next;
  logic [7:0] status_set;
  logic [7:0] read_clear;

  always_comb begin
    status_set                          = 8'h00;
    status_set[`BIT_KEY_HOLD_SHUTDOWN]  = i_key_hold_shutdown;
    status_set[`BIT_BUTTON_RISE]        = button_rise;
    status_set[`BIT_BUTTON_FALL]        = button_fall;
    status_set[`BIT_HIGH_TEMP_PREWARN]  = i_high_temp_prewarn;
    status_set[`BIT_LOW_TEMP_PREWARN]   = i_low_temp_prewarn;
    // Clear only the bits shifted out (target shift register still holds them),
    // so a set landing in the fetch or clearing cycle waits for the next read
    read_clear             = rd_status ? bus.wdata : 8'h00;
    irq_status_second_next = (irq_status_second_reg & ~read_clear) | status_set;
    irq_status_second_next = irq_status_second_next & `STATUS_LIVE_MASK;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      irq_status_second_reg <= `RST_IRQ_STATUS_SECOND;
    end else begin
      irq_status_second_reg <= irq_status_second_next;
    end
  end

  // ---------------------------------------------------------------
  // Sequence slot registers
  // ---------------------------------------------------------------
  logic [7:0] onoff_sequence_first_reg;
  logic [7:0] onoff_sequence_second_reg;
  logic       option_load_reg;

  // Options are sampled after release, never under reset itself
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      option_load_reg <= 1'b1;
    end else begin
      option_load_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      onoff_sequence_first_reg <= `RST_SEQ_HOLD;
    end else if (option_load_reg) begin
      onoff_sequence_first_reg <= i_option_seq_first;
    end else if (wr_seq_first) begin
      onoff_sequence_first_reg <= bus.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      onoff_sequence_second_reg <= `RST_SEQ_HOLD;
    end else if (option_load_reg) begin
      onoff_sequence_second_reg <= i_option_seq_second;
    end else if (wr_seq_second) begin
      onoff_sequence_second_reg <= bus.wdata;
    end
  end

  slot_t first_converter_slot;
  slot_t second_converter_slot;
  slot_t third_converter_slot;
  slot_t fourth_converter_slot;

  assign first_converter_slot  = onoff_sequence_first_reg[`SLOT_LO_MSB:`SLOT_LO_LSB];
  assign second_converter_slot = onoff_sequence_first_reg[`SLOT_HI_MSB:`SLOT_HI_LSB];
  assign third_converter_slot  = onoff_sequence_second_reg[`SLOT_LO_MSB:`SLOT_LO_LSB];
  assign fourth_converter_slot = onoff_sequence_second_reg[`SLOT_HI_MSB:`SLOT_HI_LSB];

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Unmapped offsets read as zero; writes to them are dropped
  always_comb begin
    case (bus.addr)
      `OFS_IRQ_STATUS_SECOND:     bus.rdata = irq_status_second_reg;
      `OFS_ONOFF_SEQUENCE_FIRST:  bus.rdata = onoff_sequence_first_reg;
      `OFS_ONOFF_SEQUENCE_SECOND: bus.rdata = onoff_sequence_second_reg;
      default:                    bus.rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  seq_state_e  state_reg;
  slot_t       step_reg;
  logic [15:0] wait_reg;
  slot_t       snap_slot_reg [RAILS];
  logic        step_due;

  assign step_due = (wait_reg == 16'h0000);

  // Slots are frozen at power-up so power-down mirrors the same order
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      snap_slot_reg[0] <= `SLOT_OFF;
      snap_slot_reg[1] <= `SLOT_OFF;
      snap_slot_reg[2] <= `SLOT_OFF;
      snap_slot_reg[3] <= `SLOT_OFF;
    end else if (state_reg == SEQ_OFF && i_seq_on_req && !option_load_reg) begin
      snap_slot_reg[0] <= first_converter_slot;
      snap_slot_reg[1] <= second_converter_slot;
      snap_slot_reg[2] <= third_converter_slot;
      snap_slot_reg[3] <= fourth_converter_slot;
    end
  end

  // Request waits out the option load so the snapshot never holds reset values
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_reg <= SEQ_OFF;
      step_reg  <= `SLOT_OFF;
      wait_reg  <= 16'h0000;
    end else begin
      case (state_reg)
        SEQ_OFF: begin
          if (i_seq_on_req && !option_load_reg) begin
            state_reg <= SEQ_RISE;
            step_reg  <= `SLOT_FIRST_ON;
            wait_reg  <= 16'h0000;
          end
        end
        SEQ_RISE: begin
          if (!step_due) begin
            wait_reg <= wait_reg - 16'h0001;
          end else if (step_reg == `SLOT_LAST_ON) begin
            state_reg <= SEQ_ON;
          end else begin
            step_reg <= step_reg + 4'h1;
            wait_reg <= STEP_RELOAD;
          end
        end
        SEQ_ON: begin
          if (!i_seq_on_req) begin
            state_reg <= SEQ_FALL;
            step_reg  <= `SLOT_LAST_ON;
            wait_reg  <= 16'h0000;
          end
        end
        SEQ_FALL: begin
          if (!step_due) begin
            wait_reg <= wait_reg - 16'h0001;
          end else if (step_reg == `SLOT_FIRST_ON) begin
            state_reg <= SEQ_OFF;
          end else begin
            step_reg <= step_reg - 4'h1;
            wait_reg <= STEP_RELOAD;
          end
        end
        default: begin
          state_reg <= SEQ_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Rail enables, one per converter
  // ---------------------------------------------------------------
  logic [RAILS-1:0] rail_en_reg;

  for (genvar g = 0; g < RAILS; g++) begin : g_rail
    logic slot_valid;

    // Codes 0 and 13..15 never match a step, so those rails stay off
    assign slot_valid = (snap_slot_reg[g] >= `SLOT_FIRST_ON) && (snap_slot_reg[g] <= `SLOT_LAST_ON);

    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
        rail_en_reg[g] <= 1'b0;
      end else if (state_reg == SEQ_RISE && step_due && slot_valid && snap_slot_reg[g] == step_reg) begin
        rail_en_reg[g] <= 1'b1;
      end else if (state_reg == SEQ_FALL && step_due && snap_slot_reg[g] == step_reg) begin
        rail_en_reg[g] <= 1'b0;
      end
    end
  end

  assign o_rail_en  = rail_en_reg;
  assign o_seq_busy = (state_reg == SEQ_RISE) || (state_reg == SEQ_FALL);
  assign o_seq_up   = (state_reg == SEQ_ON);

endmodule : pmic_status_and_sequence_regs

`default_nettype wire

// ---- verification/pmic_seq_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module pmic_seq_monitor #(
  parameter int SEQ_STEP_CYCLES = 20
) (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_b,
  input wire logic       i_seq_on_req,
  input wire logic [3:0] o_rail_en,
  input wire logic       o_seq_busy,
  input wire logic       o_seq_up
);
  // ------------------
  // Ramp direction
  // ------------------
  // Ports cannot tell a rise from a fall, so track it here
  localparam int RAMP_MAX = 11 * SEQ_STEP_CYCLES + 8;
  logic rising_reg;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !(o_seq_busy || o_seq_up)) begin
      rising_reg <= 1'b1;
    end else if (o_seq_up) begin
      rising_reg <= 1'b0;
    end
  end
  // ------------------
  // Checks
  // ------------------
  sequence s_off_asked;
    !o_seq_busy && !o_seq_up && i_seq_on_req && $past(i_rst_b) && $past(i_rst_b, 2);
  endsequence
  sequence s_on_dropped;
    o_seq_up && !i_seq_on_req;
  endsequence
  a_rise_start: assert property (s_off_asked |=> o_seq_busy && !o_seq_up)
    else $error("ramp up not started");
  a_fall_start: assert property (s_on_dropped |=> o_seq_busy && !o_seq_up)
    else $error("ramp down not started");
  a_off_dark: assert property (!o_seq_busy && !o_seq_up |-> o_rail_en == 4'h0)
    else $error("rail on while off");
  a_up_holds: assert property (o_seq_up && i_seq_on_req |=> o_seq_up)
    else $error("on state left while requested");
  a_on_steady: assert property (o_seq_up && $past(o_seq_up) |-> $stable(o_rail_en))
    else $error("rails moved while on");
  a_rise_sets: assert property (o_seq_busy && rising_reg |=> (~o_rail_en & $past(o_rail_en)) == 4'h0)
    else $error("rail dropped in ramp up");
  a_fall_clears: assert property (o_seq_busy && !rising_reg |=> (o_rail_en & ~$past(o_rail_en)) == 4'h0)
    else $error("rail raised in ramp down");
  a_ramp_ends: assert property ($rose(o_seq_busy) |-> ##[1:RAMP_MAX] !o_seq_busy)
    else $error("ramp too long");
  a_rise_lands: assert property ($fell(o_seq_busy) && rising_reg |-> o_seq_up)
    else $error("ramp up did not end on");
endmodule : pmic_seq_monitor

bind pmic_status_and_sequence_regs pmic_seq_monitor #(.SEQ_STEP_CYCLES(SEQ_STEP_CYCLES)) u_monitor (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_seq_on_req(i_seq_on_req),
  .o_rail_en(o_rail_en), .o_seq_busy(o_seq_busy), .o_seq_up(o_seq_up)
);
`default_nettype wire

// ---- verification/host_two_wire_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_two_wire_model #(
  parameter logic [6:0] ADDR = 7'h34
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  // ------------------
  // Bus phases
  // ------------------
  // Seven clocks a phase, above the four-clock minimum
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic ph(input logic c, input logic d, output logic s);
    @(posedge i_clk_sys);
    o_scl     <= c;
    o_sda_low <= ~d;
    repeat (6) @(posedge i_clk_sys);
    s = i_sda;
  endtask : ph
  // Data moves only while clock is low
  task automatic bit1(input logic d, output logic s);
    logic x;
    ph(1'b0, d, x);
    ph(1'b1, d, s);
    ph(1'b0, d, x);
  endtask : bit1
  task automatic start();
    logic x;
    ph(1'b0, 1'b1, x);
    ph(1'b1, 1'b1, x);
    ph(1'b1, 1'b0, x);
    ph(1'b0, 1'b0, x);
  endtask : start
  task automatic stop();
    logic x;
    ph(1'b0, 1'b0, x);
    ph(1'b1, 1'b0, x);
    ph(1'b1, 1'b1, x);
  endtask : stop
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r);
    logic k;
    for (int i = 7; i >= 0; i--) begin
      bit1(w[i], r[i]);
    end
    bit1(a, k);
  endtask : xfer
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r);
    xfer(p, 1'b1, r);
    xfer(d, 1'b1, r);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r);
    xfer(p, 1'b1, r);
    start();
    xfer({ADDR, 1'b1}, 1'b1, r);
    xfer(8'hff, 1'b1, d);
    stop();
  endtask : read_reg
endmodule : host_two_wire_model
`default_nettype wire

// ---- verification/pmic_status_and_sequence_regs_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module pmic_status_and_sequence_regs_tb_top;
  import pmic_seq_pkg::*;
  // ------------------
  // Harness
  // ------------------
  localparam int STEP = 2;
  logic        i_clk_sys, i_rst_b, scl, sda, host_low, sda_o, sda_oe;
  logic        btn, key, hot, warm, req, busy, up;
  logic [7:0]  opt1, opt2, rd;
  logic [3:0]  rails, sl [4];
  logic [31:0] seed = 32'hbdb5;
  int          err_total, total_checks, cyc, t_on [4], t_off [4];
  int          bits [5] = '{7, 1, 0, 6, 5};
  // Pulled-up data line
  assign sda = host_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  pmic_status_and_sequence_regs #(.SEQ_STEP_CYCLES(STEP)) dut (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_power_button_input(btn),
    .i_key_hold_shutdown(key), .i_high_temp_prewarn(hot), .i_low_temp_prewarn(warm),
    .i_option_seq_first(opt1), .i_option_seq_second(opt2), .i_seq_on_req(req),
    .o_rail_en(rails), .o_seq_busy(busy), .o_seq_up(up)
  );
  host_two_wire_model host (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  function automatic bit live(input logic [3:0] s);
    return s >= 4'h1 && s <= 4'hc;
  endfunction : live
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Edge times of each rail; run ceiling
  always @(posedge i_clk_sys) begin
    cyc++;
    for (int r = 0; r < 4; r++) begin
      if (rails[r] && t_on[r] < 0) t_on[r] = cyc;
      if (!rails[r] && t_on[r] >= 0 && t_off[r] < 0) t_off[r] = cyc;
    end
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end
  // ------------------
  // Sequencer round
  // ------------------
  task automatic round(input logic [7:0] a, input logic [7:0] b);
    int smin, smax, ton, toff;
    logic [3:0] m;
    host.write_reg(8'h2c, a);
    host.write_reg(8'h2d, b);
    host.read_reg(8'h2c, rd);
    check(rd, a);
    host.read_reg(8'h2d, rd);
    check(rd, b);
    sl = '{a[3:0], a[7:4], b[3:0], b[7:4]};
    {smin, smax, ton, toff} = {32'd13, 32'd0, 32'd99999, 32'd99999};
    for (int r = 0; r < 4; r++) begin
      m[r] = live(sl[r]);
      t_on[r] = -1;
      t_off[r] = -1;
    end
    req <= 1'b1;
    for (int n = 0; n < 200 && up !== 1'b1; n++) begin
      @(posedge i_clk_sys);
    end
    check(rails, m);
    req <= 1'b0;
    for (int n = 0; n < 200 && (busy !== 1'b0 || up !== 1'b0); n++) begin
      @(posedge i_clk_sys);
    end
    repeat (3) @(posedge i_clk_sys);
    for (int r = 0; r < 4; r++) begin
      if (m[r]) begin
        smin = (sl[r] < smin) ? sl[r] : smin;
        smax = (sl[r] > smax) ? sl[r] : smax;
        ton = (t_on[r] < ton) ? t_on[r] : ton;
        toff = (t_off[r] < toff) ? t_off[r] : toff;
      end
    end
    for (int r = 0; r < 4; r++) begin
      if (m[r]) begin
        check(t_on[r] - ton, (sl[r] - smin) * STEP);
        check(t_off[r] - toff, (smax - sl[r]) * STEP);
      end else begin
        check(t_on[r], -1);
      end
    end
  endtask : round
  initial begin
    {i_rst_b, btn, key, hot, warm, req} = '0;
    opt1 = xs();
    opt2 = xs();
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    host.read_reg(8'h2b, rd);
    check(rd, 8'h00);
    host.read_reg(8'h2c, rd);
    check(rd, opt1);
    host.read_reg(8'h2d, rd);
    check(rd, opt2);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk_sys);
      case (i)
        0: key <= 1'b1;
        1: hot <= 1'b1;
        2: warm <= 1'b1;
        3: btn <= 1'b1;
        default: btn <= 1'b0;
      endcase
      @(posedge i_clk_sys);
      {key, hot, warm} <= '0;
      repeat (5) @(posedge i_clk_sys);
      host.read_reg(8'h2b, rd);
      check(rd, 8'h01 << bits[i]);
      host.read_reg(8'h2b, rd);
      check(rd, 8'h00);
    end
    // Input held across the clearing read must keep its flag
    hot <= 1'b1;
    host.read_reg(8'h2b, rd);
    check(rd, 8'h02);
    hot <= 1'b0;
    host.read_reg(8'h2b, rd);
    check(rd, 8'h02);
    host.write_reg(8'h2b, 8'hff);
    host.read_reg(8'h2b, rd);
    check(rd, 8'h00);
    host.read_reg(8'h40, rd);
    check(rd, 8'h00);
    $display("test status done");
    round(8'h1c, 8'h0d);
    round(8'h55, 8'hf5);
    for (int i = 0; i < 3; i++) begin
      round(xs(), xs());
    end
    $display("test sequencer done");
    conclude();
  end
endmodule : pmic_status_and_sequence_regs_tb_top
`default_nettype wire
